// *** rtl/cts_sequencer.sv ***
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Function
// R1 - Sample every 8 s, end on slope
// R2 - Quiet charge and timing pins before sampling
// R3 - Sample only in constant-current fast charge
// R4 - Voltage limit marks lithium, stops sampling
// R5 - Lithium ends at 7% current taper
// R6 - Nickel measures capacitor; lithium continues voltage stage
// R7 - Top-off chosen from capacitor and resistor
// R8 - Top-off reloads timer, ends on events
// R9 - Top-off one pulse per second
// R10 - Lamp off in top-off and trickle
// R11 - Cold pauses top-off, trickles, resumes
// R12 - Hot stops top-off, timer keeps running
// R13 - Cutoff stops charge, later trickle only
// R14 - Trickle pulse each second, programmed width
// R15 - Top-off pulse width is 62.5 ms
// R16 - Sleep grounds timing pin; sample dips
// R17 - Timer idle states hold steady pin
// R18 - Timer running states oscillate pin
// R19 - Voltage limit ends maintenance for good; ST_TOP_HOT and ST_CUTOFF do not check it
// R20 - Hot suspends trickle until clear
// R21 - Otherwise trickle continues indefinitely
// R22 - Slope test held off for time/32
// R23 - Comparator flags synchronised before use
module cts_sequencer
  import cts_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = CLK_HZ * TICK_SEC, // Cycles per one-second period
  parameter int unsigned QUIET_CYC   = QUIET_CYC_DEF,     // Quiet time ahead of a conversion
  parameter int unsigned ADC_W       = 10                 // Temperature sample width
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Comparator flags from the analog front end
  input  wire cts_pkg::cts_flags_t cmp_flags_raw,
  // Temperature ADC
  output logic                   adc_start,
  input  wire logic              adc_valid,
  input  wire logic [ADC_W-1:0]  adc_data,
  // Pins
  output logic                   charge_pulse_output,
  output logic                   timing_pin,
  output logic                   status_lamp_output,
  output logic                   timer_running
);
  import cts_pkg::*;

  localparam logic [31:0] TICK_LAST   = 32'(CYC_PER_SEC - 1);
  localparam logic [31:0] HALF_CYC    = 32'(CYC_PER_SEC / 2);
  localparam logic [31:0] TOPOFF_CYC  = 32'(CYC_PER_SEC / TOPOFF_DIV);
  localparam logic [31:0] CYC_PER_MS  = 32'(CYC_PER_SEC / MS_PER_SEC);
  localparam logic [31:0] SLOPE_MUL   = 32'(SEC_PER_MIN * SLOPE_DIV);
  localparam logic [31:0] SLOPE_LIM   = 32'((SAMPLE_SEC * SAMPLE_SPAN) << ADC_W);
  localparam logic [2:0]  SAMPLE_LAST = 3'(SAMPLE_SEC - 1);
  localparam logic [15:0] QUIET_LAST  = 16'(QUIET_CYC - 1);

  // Flag synchroniser
  cts_flags_t        sync1_ff;      // First stage, read only by the second
  cts_flags_t        flags_ff;      // Stable flags
  // Registers
  logic              start_ff;      // One-cycle start pulse
  logic              sleep_ff;      // Sleep mode
  logic [15:0]       maxtime_ff;    // Max charge time, seconds
  logic [15:0]       cap_ff;        // Measured timing capacitor, nF
  logic [15:0]       res_ff;        // Measured timing resistor, kOhm
  logic [15:0]       trickle_ff;    // Trickle pulse width, ms
  logic [31:0]       rdata_ff;
  logic              slverr_ff;
  // Sequencer
  cts_state_t        state_ff, nxt_state;
  logic              li_ff;         // Pack classified lithium
  logic              topen_ff;      // Top-off selected
  logic [31:0]       cyc_ff;        // Position in the one-second period
  logic              tick;
  logic [16:0]       remain_ff;     // Timer seconds left
  logic [16:0]       fast_sec_ff;   // Seconds spent in constant-current charge
  logic [2:0]        sec8_ff;       // Seconds within the sample period
  // Sampling
  logic              quiet_ff;      // Charge and timing pins held low for a conversion
  logic              conv_ff;       // Conversion outstanding
  logic [15:0]       quiet_cnt_ff;
  logic              adc_start_ff;
  logic [ADC_W-1:0]  hist1_ff;      // Previous sample
  logic [ADC_W-1:0]  hist2_ff;      // Sample two periods back
  logic [1:0]        nsamp_ff;      // Samples held, saturating at two
  logic              slope_hit_ff;  // Slope reached, one cycle
  logic [ADC_W-1:0]  decline;
  logic              slope_ok;
  logic              capture;
  // Output stage
  logic              charge_ff, nxt_charge;
  logic              pin_ff, nxt_pin;
  logic              lamp_ff, nxt_lamp;
  logic              run;
  logic              expired;
  logic              ld_full, ld_add;
  logic [31:0]       trickle_cyc;

  // Two flops ahead of every state decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      flags_ff <= '0;
    end else begin
      sync1_ff <= cmp_flags_raw; // R23
      flags_ff <= sync1_ff;      // R23
    end
  end

  // APB: zero wait states, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = rdata_ff;
  assign pslverr = slverr_ff;

  // Register writes at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_ff   <= 1'b0;
      sleep_ff   <= 1'b0;
      maxtime_ff <= MAXTIME_RST;
      cap_ff     <= CAP_RST;
      res_ff     <= RES_RST;
      trickle_ff <= TRICKLE_RST;
    end else begin
      start_ff <= 1'b0;
      if (psel && penable && pwrite) begin
        case (paddr)
          OFS_CTRL: begin
            start_ff <= pwdata[CTRL_START_BIT];
            sleep_ff <= pwdata[CTRL_SLEEP_BIT];
          end
          OFS_MAXTIME: maxtime_ff <= pwdata[15:0];
          OFS_TIMING: begin
            cap_ff <= pwdata[15:0];
            res_ff <= pwdata[TIMING_RES_LSB +: 16];
          end
          OFS_TRICKLE: trickle_ff <= pwdata[15:0];
          default: ; // Read-only or unmapped: no effect
        endcase
      end
    end
  end

  // Read mux and error flag, loaded in setup so they stand through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff  <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      rdata_ff  <= 32'h0000_0000;
      slverr_ff <= 1'b0;
      case (paddr)
        OFS_CTRL:    rdata_ff[CTRL_SLEEP_BIT] <= sleep_ff;
        OFS_MAXTIME: rdata_ff[15:0] <= maxtime_ff;
        OFS_TIMING:  rdata_ff <= {res_ff, cap_ff};
        OFS_TRICKLE: rdata_ff[15:0] <= trickle_ff;
        OFS_STATUS: begin
          rdata_ff[3:0]          <= state_ff;
          rdata_ff[STAT_LI_BIT]  <= li_ff;
          rdata_ff[STAT_TOP_BIT] <= topen_ff;
          rdata_ff[STAT_RUN_BIT] <= run;
          rdata_ff[STAT_FLAG_LSB +: 5] <= flags_ff;
        end
        OFS_TIMER:   rdata_ff[16:0] <= remain_ff;
        OFS_SAMPLE:  rdata_ff[ADC_W-1:0] <= hist1_ff;
        default:     slverr_ff <= 1'b1; // Unmapped address
      endcase
    end
  end

  // One-second divider; every slower rate is the tick
  assign tick = (cyc_ff == TICK_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= 32'h0000_0000;
    end else if (tick) begin
      cyc_ff <= 32'h0000_0000;
    end else begin
      cyc_ff <= cyc_ff + 32'h0000_0001;
    end
  end

  // Timer runs only in these states; all others hold it
  always_comb begin
    case (state_ff)
      ST_FAST_CC, ST_FAST_CV, ST_TOPOFF, ST_TOP_HOT, ST_DONE: run = !sleep_ff; // R18
      default: run = 1'b0; // R17
    endcase
  end
  assign expired = (remain_ff == 17'h0_0000);

  // Charge timer in seconds left
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain_ff <= 17'h0_0000;
    end else if (ld_full) begin
      remain_ff <= {1'b0, maxtime_ff}; // R8
    end else if (ld_add) begin
      // Lithium gets a further full period on top of what is left
      remain_ff <= remain_ff + {1'b0, maxtime_ff};
    end else if (tick && run && !expired) begin
      remain_ff <= remain_ff - 17'h0_0001;
    end
  end

  // Hold-off clock and sample period position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_sec_ff <= 17'h0_0000;
      sec8_ff     <= 3'h0;
    end else if (start_ff) begin
      fast_sec_ff <= 17'h0_0000;
      sec8_ff     <= 3'h0;
    end else if (tick && state_ff == ST_FAST_CC) begin
      if (fast_sec_ff != 17'h1_ffff) begin
        fast_sec_ff <= fast_sec_ff + 17'h0_0001;
      end
      sec8_ff <= sec8_ff + 3'h1; // R1
    end
  end

  // Slope test allowed only for nickel in constant current, after hold-off
  assign slope_ok = (state_ff == ST_FAST_CC) && !li_ff // R3 R4
                    && (fast_sec_ff >= {6'h00, maxtime_ff[15:HOLDOFF_SHIFT]}); // R22
  assign capture  = conv_ff && adc_valid;
  assign decline  = (hist2_ff > adc_data) ? (hist2_ff - adc_data) : '0;

  // Sample sequencer: quiet, convert, compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_ff     <= 1'b0;
      conv_ff      <= 1'b0;
      quiet_cnt_ff <= 16'h0000;
      adc_start_ff <= 1'b0;
    end else begin
      adc_start_ff <= 1'b0;
      if (state_ff != ST_FAST_CC || sleep_ff) begin
        // Leaving constant current drops any conversion in flight
        quiet_ff <= 1'b0;
        conv_ff  <= 1'b0;
      end else if (!quiet_ff) begin
        if (tick && sec8_ff == SAMPLE_LAST) begin
          quiet_ff     <= 1'b1; // R1 R2 R3
          quiet_cnt_ff <= 16'h0000;
        end
      end else if (!conv_ff) begin
        if (quiet_cnt_ff == QUIET_LAST) begin
          conv_ff      <= 1'b1;
          adc_start_ff <= 1'b1; // R1
        end else begin
          quiet_cnt_ff <= quiet_cnt_ff + 16'h0001;
        end
      end else if (adc_valid) begin
        quiet_ff <= 1'b0;
        conv_ff  <= 1'b0;
      end
    end
  end
  assign adc_start = adc_start_ff;

  // Sample history and decline check against two periods back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist1_ff     <= '0;
      hist2_ff     <= '0;
      nsamp_ff     <= 2'h0;
      slope_hit_ff <= 1'b0;
    end else if (start_ff) begin
      nsamp_ff     <= 2'h0;
      slope_hit_ff <= 1'b0;
    end else begin
      slope_hit_ff <= 1'b0;
      if (capture) begin
        hist1_ff <= adc_data;
        hist2_ff <= hist1_ff;
        if (nsamp_ff != 2'h2) begin
          nsamp_ff <= nsamp_ff + 2'h1;
        end
        // Voltage falls as the pack warms; decline x 60 x 161 against span x full scale
        if (nsamp_ff == 2'h2 && slope_ok && (32'(decline) * SLOPE_MUL >= SLOPE_LIM)) begin
          slope_hit_ff <= 1'b1; // R1
        end
      end
    end
  end

  // Chemistry and top-off choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      li_ff    <= 1'b0;
      topen_ff <= 1'b0;
    end else if (start_ff) begin
      li_ff    <= 1'b0;
      topen_ff <= 1'b0;
    end else begin
      if (state_ff == ST_FAST_CC && flags_ff.vlimit) begin
        li_ff <= 1'b1; // R4
      end
      if (state_ff == ST_CAP_MEAS) begin
        // Between 70 and 130 nF is left unselected
        topen_ff <= (cap_ff > TOPOFF_CAP_MIN_NF) && (res_ff < TOPOFF_RES_MAX_K) // R7
                    && !(cap_ff < NOTOP_CAP_MAX_NF);                            // R7
      end
    end
  end

  // Next state; top-off takes voltage limit, cutoff, hot, cold, time; fast charge takes cutoff, cold, voltage limit, time
  always_comb begin
    nxt_state = state_ff;
    ld_full   = 1'b0;
    ld_add    = 1'b0;
    if (start_ff) begin
      nxt_state = ST_FAST_CC;
      ld_full   = 1'b1;
    end else if (sleep_ff) begin
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_FAST_CC: begin
          if (flags_ff.cutoff) nxt_state = ST_CUTOFF;
          else if (flags_ff.cold) nxt_state = ST_COLD_PAUSE;
          else if (flags_ff.vlimit) begin
            nxt_state = ST_FAST_CV; // R4 R6
            ld_add    = 1'b1;
          end else if (expired || slope_hit_ff) nxt_state = ST_CAP_MEAS; // R1 R6
        end
        ST_FAST_CV: begin
          if (flags_ff.cutoff) nxt_state = ST_CUTOFF;
          else if (flags_ff.cold) nxt_state = ST_COLD_PAUSE;
          else if (flags_ff.taper || expired) nxt_state = ST_DONE; // R5
        end
        ST_COLD_PAUSE: begin
          if (flags_ff.cutoff) nxt_state = ST_CUTOFF;
          else if (!flags_ff.cold) nxt_state = li_ff ? ST_FAST_CV : ST_FAST_CC;
        end
        ST_CAP_MEAS: begin
          // Until the next tick, just under one period, to settle the capacitor reading
          if (tick) begin
            if ((cap_ff > TOPOFF_CAP_MIN_NF) && (res_ff < TOPOFF_RES_MAX_K)) begin
              nxt_state = ST_TOPOFF; // R6 R7
              ld_full   = 1'b1;      // R8
            end else begin
              nxt_state = ST_TRICKLE; // R6 R7
            end
          end
        end
        ST_TOPOFF: begin
          if (flags_ff.vlimit) nxt_state = ST_HALT;           // R8 R19
          else if (flags_ff.cutoff) nxt_state = ST_CUTOFF;    // R13
          else if (flags_ff.hot) nxt_state = ST_TOP_HOT;      // R12
          else if (flags_ff.cold) nxt_state = ST_TOP_COLD;    // R11
          else if (expired) nxt_state = ST_TRICKLE;           // R8
        end
        ST_TOP_COLD: begin
          if (flags_ff.vlimit) nxt_state = ST_HALT;           // R19
          else if (flags_ff.cutoff) nxt_state = ST_CUTOFF;    // R13
          else if (flags_ff.hot) nxt_state = ST_TOP_HOT;
          else if (!flags_ff.cold) nxt_state = ST_TOPOFF;     // R11
        end
        ST_TOP_HOT: begin
          if (flags_ff.cutoff) nxt_state = ST_CUTOFF;         // R13
          else if (!flags_ff.hot) nxt_state = expired ? ST_TRICKLE : ST_TOPOFF; // R12
        end
        ST_CUTOFF: begin
          if (!flags_ff.cutoff && !flags_ff.hot) nxt_state = ST_TRICKLE; // R13
        end
        ST_TRICKLE: begin
          if (flags_ff.vlimit) nxt_state = ST_HALT;           // R19
          else if (flags_ff.hot) nxt_state = ST_TRICKLE_HOT;  // R20
        end
        ST_TRICKLE_HOT: begin
          if (flags_ff.vlimit) nxt_state = ST_HALT;           // R19
          else if (!flags_ff.hot) nxt_state = ST_TRICKLE;     // R20
        end
        ST_IDLE, ST_DONE, ST_HALT: nxt_state = state_ff;    // R19 R21
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Output decode
  assign trickle_cyc = 32'(trickle_ff) * CYC_PER_MS;
  always_comb begin
    nxt_charge = 1'b0;
    nxt_lamp   = 1'b0; // R10
    nxt_pin    = 1'b1; // R17
    case (state_ff)
      ST_FAST_CC, ST_FAST_CV: begin
        // Current loop outside does the modulation; this only enables it
        nxt_charge = 1'b1;
        nxt_lamp   = 1'b1;
      end
      ST_COLD_PAUSE: nxt_lamp = (cyc_ff < HALF_CYC);
      ST_TOPOFF: nxt_charge = (cyc_ff < TOPOFF_CYC); // R9 R15
      ST_TOP_COLD, ST_TRICKLE: nxt_charge = (cyc_ff < trickle_cyc); // R11 R14 R21
      default: nxt_charge = 1'b0; // R12 R13 R19 R20
    endcase
    if (run) begin
      nxt_pin = (cyc_ff < HALF_CYC); // R18
    end
    if (quiet_ff) begin
      nxt_charge = 1'b0; // R2
      nxt_pin    = 1'b0; // R2 R16
    end
    if (sleep_ff) begin
      nxt_charge = 1'b0;
      nxt_lamp   = 1'b0;
      nxt_pin    = 1'b0; // R16
    end
  end

  // Registered pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_ff <= 1'b0;
      pin_ff    <= 1'b1;
      lamp_ff   <= 1'b0;
    end else begin
      charge_ff <= nxt_charge;
      pin_ff    <= nxt_pin;
      lamp_ff   <= nxt_lamp;
    end
  end

  assign charge_pulse_output = charge_ff;
  assign timing_pin          = pin_ff;
  assign status_lamp_output  = lamp_ff;
  assign timer_running       = run;

endmodule

// *** rtl/cts_pkg.sv ***
package cts_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ         = 40_000_000; // pclk rate
  localparam int unsigned TICK_SEC       = 1;          // Maintenance pulse period, seconds
  localparam int unsigned TOPOFF_DIV     = 16;         // Top-off pulse is 1/16 of a period (62.5 ms)
  localparam int unsigned MS_PER_SEC     = 1000;       // Trickle width unit conversion
  localparam int unsigned QUIET_CYC_DEF  = 16;         // Quiet cycles before a conversion starts

  // Slope test: decline of supply/161 per minute over two 8 s periods
  localparam int unsigned SAMPLE_SEC     = 8;
  localparam int unsigned SAMPLE_SPAN    = 2;
  localparam int unsigned SEC_PER_MIN    = 60;
  localparam int unsigned SLOPE_DIV      = 161;
  localparam int unsigned HOLDOFF_SHIFT  = 5;          // Hold-off is max charge time / 32

  // Top-off selection from the measured timing parts
  localparam logic [15:0] TOPOFF_CAP_MIN_NF = 16'h0082; // Above 130 nF
  localparam logic [15:0] TOPOFF_RES_MAX_K  = 16'h00fa; // Below 250 kOhm
  localparam logic [15:0] NOTOP_CAP_MAX_NF  = 16'h0046; // Below 70 nF

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_MAXTIME = 8'h04;
  localparam logic [7:0] OFS_TIMING  = 8'h08;
  localparam logic [7:0] OFS_TRICKLE = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_TIMER   = 8'h14;
  localparam logic [7:0] OFS_SAMPLE  = 8'h18;

  // Control fields
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_SLEEP_BIT = 1;
  // Timing register fields: capacitance nF low half, resistance kOhm high half
  localparam int unsigned TIMING_RES_LSB = 16;
  // Status fields
  localparam int unsigned STAT_LI_BIT    = 4;
  localparam int unsigned STAT_TOP_BIT   = 5;
  localparam int unsigned STAT_RUN_BIT   = 6;
  localparam int unsigned STAT_FLAG_LSB  = 7;

  // Reset values
  localparam logic [15:0] MAXTIME_RST  = 16'h0e10; // 3600 s
  localparam logic [15:0] CAP_RST      = 16'h0000;
  localparam logic [15:0] RES_RST      = 16'h0000;
  localparam logic [15:0] TRICKLE_RST  = 16'h003e; // 62 ms

  // Synchronised comparator flags
  typedef struct packed {
    logic cold;    // Below low-temperature fault level
    logic hot;     // Past high-temperature fault level
    logic cutoff;  // Past temperature cutoff level
    logic vlimit;  // Cell voltage at its limit
    logic taper;   // Current fallen to 7% of maximum
  } cts_flags_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_FAST_CC, ST_FAST_CV, ST_COLD_PAUSE, ST_CAP_MEAS, ST_TOPOFF, ST_TOP_COLD,
    ST_TOP_HOT, ST_CUTOFF, ST_TRICKLE, ST_TRICKLE_HOT, ST_DONE, ST_HALT
  } cts_state_t;

endpackage

// *** dv/cts_sequencer_asserts.sv ***
`timescale 1ns/1ps
// Pin-level checks beside the sequencer
module cts_sequencer_asserts
  import cts_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = 1024 // Cycles per second
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Pins
  input wire logic        adc_start,
  input wire logic        adc_valid,
  input wire logic        charge_pulse_output,
  input wire logic        timing_pin,
  input wire logic        status_lamp_output,
  input wire logic        timer_running
);
  logic        quiet;       // Charge and timing pin both low
  logic        pin_q_ff;    // Timing pin one cycle back
  int unsigned run_cnt_ff;  // Cycles the pin held still while timing
  logic [1:0]  idle_cnt_ff; // Idle cycles seen, stops at 3 so it never wraps
  assign quiet = !charge_pulse_output && !timing_pin;
  // Pin history; tells a running timer from a stuck one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q_ff    <= 1'b1;
      run_cnt_ff  <= 0;
      idle_cnt_ff <= 2'h0;
    end else begin
      pin_q_ff    <= timing_pin;
      run_cnt_ff  <= (timer_running && timing_pin == pin_q_ff) ? run_cnt_ff + 1 : 0;
      idle_cnt_ff <= timer_running ? 2'h0 : ((idle_cnt_ff == 2'h3) ? 2'h3 : idle_cnt_ff + 2'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_adc_one; adc_start |=> !adc_start; endproperty
  a_adc_one: assert property (p_adc_one) else $error("conversion request wider than one cycle");
  property p_quiet; adc_start |-> quiet; endproperty
  a_quiet: assert property (p_quiet) else $error("pins not quiet at conversion");
  property p_quiet_lead; adc_start |-> $past(quiet, 8); endproperty
  a_quiet_lead: assert property (p_quiet_lead) else $error("quiet time too short");
  property p_quiet_hold; adc_start |=> quiet until_with adc_valid; endproperty
  a_quiet_hold: assert property (p_quiet_hold) else $error("pins woke before conversion ended");
  property p_sleep; psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_SLEEP_BIT]
    |-> ##[1:4] (quiet && !status_lamp_output); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not ground pins");
  property p_run_pin; timer_running |-> run_cnt_ff < 2 * CYC_PER_SEC; endproperty
  a_run_pin: assert property (p_run_pin) else $error("timing pin still while timer runs");
  property p_idle_pin; !timer_running && idle_cnt_ff == 2'h3 |-> timing_pin == pin_q_ff; endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("timing pin moved while timer idle");
  property p_reset_out; $rose(presetn) |-> timing_pin && !charge_pulse_output && !timer_running; endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
endmodule
bind cts_sequencer cts_sequencer_asserts #(.CYC_PER_SEC(CYC_PER_SEC)) cts_sequencer_asserts_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .adc_start, .adc_valid, .charge_pulse_output,
  .timing_pin, .status_lamp_output, .timer_running);

// *** dv/cts_adc_model.sv ***
`timescale 1ns/1ps
// Temperature converter on the far side; answers each request after a delay
module cts_adc_model #(
  parameter int unsigned W   = 10, // Sample width
  parameter int unsigned DLY = 3   // Cycles from request to answer
) (
  // Clock
  input  wire logic         clk,
  // Request and value to return next
  input  wire logic         adc_start,
  input  wire logic [W-1:0] smp,
  // Answer
  output logic              adc_valid,
  output logic [W-1:0]      adc_data
);
  int unsigned wait_ff; // Cycles left until the answer
  initial begin
    wait_ff   = 0;
    adc_valid = 1'b0;
    adc_data  = '0;
  end
  // Data flips every cycle outside valid, so a stale value cannot pass
  always @(posedge clk) begin
    adc_valid <= 1'b0;
    adc_data  <= ~adc_data;
    if (adc_start) begin
      wait_ff <= DLY;
    end else if (wait_ff == 1) begin
      wait_ff   <= 0;
      adc_valid <= 1'b1;
      adc_data  <= smp;
    end else if (wait_ff != 0) begin
      wait_ff <= wait_ff - 1;
    end
  end
endmodule

// *** dv/cts_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; $display("FAIL %s exp %0h got %0h", nm, exp, got); end end
module cts_sequencer_tb_top;
  import cts_pkg::*;
  localparam int unsigned CPS = 1024; // Short second keeps the run brief
  localparam logic [9:0]  SMP [3] = '{10'h258, 10'h258, 10'h24e}; // Third sample hotter
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        adc_start, adc_valid, charge_pulse_output, timing_pin, status_lamp_output, timer_running;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  adc_data, smp;
  cts_flags_t  flg;
  int          num_errors, n_compared, c, n;
  // Design and converter
  cts_sequencer #(.CYC_PER_SEC(CPS)) cts_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cmp_flags_raw(flg), .adc_start, .adc_valid, .adc_data, .charge_pulse_output,
    .timing_pin, .status_lamp_output, .timer_running);
  cts_adc_model cts_adc_model_inst (.clk(pclk), .adc_start, .smp, .adc_valid, .adc_data);
  always #12.5 pclk = ~pclk;
  // One bus transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    `CHK("ready err", {1'b1, a > OFS_SAMPLE}, {pready, pslverr})
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // State field of the status word
  task automatic st(input logic [3:0] s, input string nm);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(nm, s, rd[3:0])
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // Charge-high cycles over one second
  task automatic pulses();
    c = 0;
    repeat (CPS) begin @(posedge pclk); c += int'(charge_pulse_output); end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog sized well past the planned run
  initial begin
    cyc(90000);
    num_errors++;
    finish_test();
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; flg = '0; smp = '0;
    cyc(10);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped offset
    apb(1'b0, OFS_MAXTIME, 32'h0);
    `CHK("maxtime", 32'h0000_0e10, rd)
    apb(1'b0, OFS_TRICKLE, 32'h0);
    `CHK("trickle", 32'h0000_003e, rd)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped", 1'b1, er)
    st(4'h0, "idle");
    $display("test reset done");
    // Nickel pack: slope end, top-off with faults, trickle
    apb(1'b1, OFS_MAXTIME, 32'h0000_0040);
    apb(1'b1, OFS_TIMING, 32'h0064_00c8);
    apb(1'b1, OFS_CTRL, 32'h1);
    cyc(8);
    st(4'h1, "fast cc");
    `CHK("timer fast", 1'b1, timer_running)
    for (int i = 0; i < 3; i++) begin
      smp <= SMP[i];
      n = 0;
      while (!adc_valid && n < 9 * CPS) begin @(posedge pclk); n++; end
      `CHK("adc answer", 1'b1, adc_valid)
      @(posedge pclk);
      if (i == 1) st(4'h1, "no slope yet");
    end
    cyc(2 * CPS);
    st(4'h5, "topoff");
    `CHK("topoff sel", 1'b1, rd[STAT_TOP_BIT])
    `CHK("lamp topoff", 1'b0, status_lamp_output)
    pulses();
    `CHK("topoff width", CPS / 16, c)
    flg.cold <= 1'b1;
    cyc(8);
    st(4'h6, "top cold");
    `CHK("timer cold", 1'b0, timer_running)
    flg.cold <= 1'b0;
    cyc(8);
    st(4'h5, "cold clear");
    flg.hot <= 1'b1;
    cyc(8);
    st(4'h7, "top hot");
    `CHK("timer hot", 1'b1, timer_running)
    pulses();
    `CHK("hot charge", 0, c)
    flg.hot <= 1'b0;
    cyc(8);
    st(4'h5, "hot clear");
    flg.cutoff <= 1'b1;
    flg.hot <= 1'b1;
    cyc(8);
    st(4'h8, "cutoff");
    pulses();
    `CHK("cutoff charge", 0, c)
    flg.cutoff <= 1'b0;
    cyc(8);
    st(4'h8, "still hot");
    flg.hot <= 1'b0;
    cyc(8);
    st(4'h9, "trickle");
    `CHK("timer trickle", 1'b0, timer_running)
    pulses();
    `CHK("trickle width", 1'b1, c >= 62 && c <= 64)
    `CHK("lamp trickle", 1'b0, status_lamp_output)
    flg.hot <= 1'b1;
    cyc(8);
    st(4'ha, "trickle hot");
    flg.hot <= 1'b0;
    cyc(8);
    st(4'h9, "trickle back");
    flg.vlimit <= 1'b1;
    cyc(8);
    st(4'hc, "halt");
    flg.vlimit <= 1'b0;
    pulses();
    `CHK("halt charge", 0, c)
    st(4'hc, "halt stays");
    $display("test nickel done");
    // Lithium pack: voltage stage, taper end, then sleep
    apb(1'b1, OFS_CTRL, 32'h1);
    cyc(8);
    st(4'h1, "restart");
    flg.vlimit <= 1'b1;
    cyc(8);
    st(4'h2, "fast cv");
    `CHK("lithium", 1'b1, rd[STAT_LI_BIT])
    c = 0;
    repeat (9 * CPS) begin @(posedge pclk); c += int'(adc_start); end
    `CHK("no sampling", 0, c)
    flg.taper <= 1'b1;
    cyc(8);
    st(4'hb, "done");
    `CHK("timer done", 1'b1, timer_running)
    apb(1'b1, OFS_CTRL, 32'h2);
    cyc(8);
    `CHK("sleep pin", 1'b0, timing_pin)
    st(4'h0, "sleep idle");
    $display("test lithium done");
    finish_test();
  end
endmodule
